// >>> src/flash_gpio_pkg.sv
package flash_gpio_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] PIN_CTRL_ADDR   = 8'h20;
    localparam logic [7:0] CAPTURE_ADDR    = 8'h30;
    localparam logic [7:0] PIN_CTRL_RESET  = 8'h00;
    localparam logic [7:0] CAPTURE_RESET   = 8'h00;
    localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
    localparam logic [7:0] PIN_CTRL_MASK   = 8'h7f; // top bit unused

    // ****************************************************************
    // pin control field positions
    // ****************************************************************
    localparam int P1_CTRL   = 0;
    localparam int P1_DIR    = 1;
    localparam int P1_DATA   = 2;
    localparam int P2_CTRL   = 3;
    localparam int P2_DIR    = 4;
    localparam int P2_DATA   = 5;
    localparam int P2_IRQ_EN = 6;

    // ****************************************************************
    // capture layout and level scale
    // ****************************************************************
    localparam int CODE_W     = 4;
    localparam int LED_B_LSB  = 4;
    localparam int LED_A_LSB  = 0;
    // each code step is one fixed current step; 0 is one step, 15 is max
    localparam int LEVEL_STEP_UA = 56250;
    localparam int LEVEL_MAX_UA  = 900000;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ         = 200;
    localparam int SLOW_DELAY_US   = 250;
    localparam int DEGLITCH_US     = 8;
    localparam int SLOW_CYCLES     = SLOW_DELAY_US * CLK_MHZ;
    localparam int DEGLITCH_CYCLES = DEGLITCH_US * CLK_MHZ;
    localparam int CNT_W           = 16;
    localparam int EVENT_N         = 3;

    // ****************************************************************
    // output setup tracking
    // ****************************************************************
    typedef enum logic [1:0] {
        SETUP_IDLE    = 2'b00,
        SETUP_PENDING = 2'b01,
        SETUP_ARMED   = 2'b10
    } setup_t;

endpackage : flash_gpio_pkg

// >>> src/hold_timer.sv
`timescale 1ns/1ps

// fires once when cond has been high for LIMIT consecutive cycles
module hold_timer #(
    parameter int LIMIT = 1600,
    parameter int CNT_W = 16
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic cond,
    output logic      fire
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } timer_state_t;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

    timer_state_t cur_ff;
    timer_state_t nxt_st;

    // the count restarts whenever cond drops, so short dips never fire
    always_comb
    begin
        nxt_st = cur_ff;
        if (!cond)
        begin
            nxt_st.cnt  = '0;
            nxt_st.done = 1'b0;
        end
        else if (!cur_ff.done)
        begin
            if (cur_ff.cnt == LAST)
                nxt_st.done = 1'b1;
            else
                nxt_st.cnt = cur_ff.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            cur_ff <= '0;
        else
            cur_ff <= nxt_st;
    end

    assign fire = cond && !cur_ff.done && (cur_ff.cnt == LAST);

    // a fresh condition cannot fire during its first eight cycles
    AST_NO_EARLY_FIRE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(cond) |-> !fire [*8])
        else $error("timer fired too early");

endmodule : hold_timer

// >>> src/flash_gpio_capture.sv
`timescale 1ns/1ps

module flash_gpio_capture #(
    parameter int SLOW_CYCLES = flash_gpio_pkg::SLOW_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // multifunction pins
    input  wire logic       first_multifunction_pin_in,
    output logic            first_multifunction_pin_out,
    output logic            first_multifunction_pin_oe,
    input  wire logic       second_multifunction_pin_in,
    output logic            second_multifunction_pin_out,
    output logic            second_multifunction_pin_oe,
    // pin functions toward the core
    output logic            rf_sync_input_one,
    output logic            rf_sync_input_two,
    output logic            torch_enable,
    input  wire logic       irq_req,
    // torch select bit of the first configuration register
    input  wire logic       torch_sel_wr,
    input  wire logic       torch_sel_wdata,
    input  wire logic       flash_done,
    output logic            hw_torch_sel,
    // protection monitors
    input  wire logic       thermistor_below_trip,
    input  wire logic       vin_below_monitor,
    input  wire logic       vin_below_flash_monitor,
    input  wire logic       thermistor_mode,
    input  wire logic       vin_monitor_en,
    input  wire logic       flash_monitor_en,
    input  wire logic [3:0] led_a_code,
    input  wire logic [3:0] led_b_code,
    output logic      [2:0] event_flag_set
);

    // ****************************************************************
    // state
    // ****************************************************************
    localparam int N = flash_gpio_pkg::EVENT_N;

    typedef struct packed {
        logic [1:0]             p1_sync;
        logic [1:0]             p2_sync;
        logic [N-1:0]           mon_meta;
        logic [N-1:0]           mon_sync;
        logic [7:0]             pin_cfg;
        logic [7:0]             eff_cfg;
        logic [7:0]             last_wr;
        flash_gpio_pkg::setup_t setup;
        logic [7:0]             captured;
        logic [N-1:0]           flag_set;
        logic                   hw_torch;
        logic [7:0]             rdata;
    } core_state_t;

    core_state_t cur_ff;
    core_state_t nxt_st;
    logic [N-1:0] cond;
    logic [N-1:0] fire;
    logic         cfg_wr;
    logic         out_req;
    logic         irq_mode;

    // drop output directions so a single first write cannot drive pins
    function automatic logic [7:0] strip_out(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        r[flash_gpio_pkg::P1_DIR] = 1'b0;
        r[flash_gpio_pkg::P2_DIR] = 1'b0;
        return r;
    endfunction : strip_out

    assign cfg_wr = reg_wr_en && (reg_addr == flash_gpio_pkg::PIN_CTRL_ADDR);
    assign out_req =
        (reg_wdata[flash_gpio_pkg::P1_CTRL] && reg_wdata[flash_gpio_pkg::P1_DIR])
        || (reg_wdata[flash_gpio_pkg::P2_CTRL]
            && reg_wdata[flash_gpio_pkg::P2_DIR]);

    // ****************************************************************
    // protection event timers
    // ****************************************************************
    // synchronised comparator levels gated by their enables
    assign cond[0] = cur_ff.mon_sync[0] && thermistor_mode;
    assign cond[1] = cur_ff.mon_sync[1] && vin_monitor_en;
    assign cond[2] = cur_ff.mon_sync[2] && flash_monitor_en;

    generate
        for (genvar g = 0; g < N; g++)
        begin : g_timer
            // slow events wait the long delay, flash monitor deglitches
            hold_timer #(
                .LIMIT ((g == 2) ? flash_gpio_pkg::DEGLITCH_CYCLES
                                 : SLOW_CYCLES),
                .CNT_W (flash_gpio_pkg::CNT_W)
            ) u_timer (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .cond     (cond[g]),
                .fire     (fire[g])
            );
        end
    endgenerate

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        nxt_st          = cur_ff;
        // first stages feed only the second stages
        nxt_st.p1_sync  = {cur_ff.p1_sync[0], first_multifunction_pin_in};
        nxt_st.p2_sync  = {cur_ff.p2_sync[0], second_multifunction_pin_in};
        nxt_st.mon_meta = {vin_below_flash_monitor, vin_below_monitor,
                           thermistor_below_trip};
        nxt_st.mon_sync = cur_ff.mon_meta;

        if (cfg_wr)
        begin
            nxt_st.last_wr = reg_wdata;
            // readback image; input data sampled only here
            nxt_st.pin_cfg = reg_wdata & flash_gpio_pkg::PIN_CTRL_MASK;
            if (!reg_wdata[flash_gpio_pkg::P1_DIR])
                nxt_st.pin_cfg[flash_gpio_pkg::P1_DATA] =
                    cur_ff.p1_sync[1];
            if (!reg_wdata[flash_gpio_pkg::P2_DIR])
                nxt_st.pin_cfg[flash_gpio_pkg::P2_DATA] =
                    cur_ff.p2_sync[1];
            case (cur_ff.setup)
                flash_gpio_pkg::SETUP_ARMED:
                begin
                    nxt_st.eff_cfg = reg_wdata
                        & flash_gpio_pkg::PIN_CTRL_MASK;
                end
                flash_gpio_pkg::SETUP_PENDING:
                begin
                    if (out_req && (reg_wdata == cur_ff.last_wr))
                    begin
                        nxt_st.eff_cfg = reg_wdata
                            & flash_gpio_pkg::PIN_CTRL_MASK;
                        nxt_st.setup   = flash_gpio_pkg::SETUP_ARMED;
                    end
                    else if (out_req)
                        nxt_st.eff_cfg = strip_out(reg_wdata
                            & flash_gpio_pkg::PIN_CTRL_MASK);
                    else
                    begin
                        nxt_st.eff_cfg = reg_wdata
                            & flash_gpio_pkg::PIN_CTRL_MASK;
                        nxt_st.setup   = flash_gpio_pkg::SETUP_IDLE;
                    end
                end
                default:
                begin
                    // first write of an output setup only makes it pending
                    nxt_st.eff_cfg = strip_out(reg_wdata
                        & flash_gpio_pkg::PIN_CTRL_MASK);
                    nxt_st.setup   = out_req ? flash_gpio_pkg::SETUP_PENDING
                                             : flash_gpio_pkg::SETUP_IDLE;
                end
            endcase
        end

        // flag and capture load on the same edge
        nxt_st.flag_set = fire;
        if (|fire)
            nxt_st.captured = {led_b_code, led_a_code};

        // a software write of the bit beats the automatic clear
        if (torch_sel_wr)
            nxt_st.hw_torch = torch_sel_wdata;
        else if (flash_done)
            nxt_st.hw_torch = 1'b0;

        // read data registered, unmapped addresses read zero
        nxt_st.rdata = flash_gpio_pkg::READ_IDLE_VALUE;
        if (reg_rd_en && (reg_addr == flash_gpio_pkg::PIN_CTRL_ADDR))
            nxt_st.rdata = cur_ff.pin_cfg;
        else if (reg_rd_en && (reg_addr == flash_gpio_pkg::CAPTURE_ADDR))
            nxt_st.rdata = cur_ff.captured;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cur_ff          <= '0;
            cur_ff.pin_cfg  <= flash_gpio_pkg::PIN_CTRL_RESET;
            cur_ff.eff_cfg  <= flash_gpio_pkg::PIN_CTRL_RESET;
            cur_ff.setup    <= flash_gpio_pkg::SETUP_IDLE;
            cur_ff.captured <= flash_gpio_pkg::CAPTURE_RESET;
        end
        else
            cur_ff <= nxt_st;
    end

    // ****************************************************************
    // pin drive and functions
    // ****************************************************************
    assign irq_mode = cur_ff.eff_cfg[flash_gpio_pkg::P2_IRQ_EN]
        && cur_ff.eff_cfg[flash_gpio_pkg::P2_DIR]
        && cur_ff.eff_cfg[flash_gpio_pkg::P2_CTRL];
    assign first_multifunction_pin_oe  =
        cur_ff.eff_cfg[flash_gpio_pkg::P1_CTRL]
        && cur_ff.eff_cfg[flash_gpio_pkg::P1_DIR];
    assign first_multifunction_pin_out =
        cur_ff.eff_cfg[flash_gpio_pkg::P1_DATA];
    assign second_multifunction_pin_oe =
        cur_ff.eff_cfg[flash_gpio_pkg::P2_CTRL]
        && cur_ff.eff_cfg[flash_gpio_pkg::P2_DIR];
    // interrupt level bypasses the data bit in interrupt mode
    assign second_multifunction_pin_out = irq_mode ? irq_req
        : cur_ff.eff_cfg[flash_gpio_pkg::P2_DATA];
    // first pin defers to the torch select when not a gpio
    assign rf_sync_input_one = !cur_ff.eff_cfg[flash_gpio_pkg::P1_CTRL]
        && !cur_ff.hw_torch && cur_ff.p1_sync[1];
    assign torch_enable = !cur_ff.eff_cfg[flash_gpio_pkg::P1_CTRL]
        && cur_ff.hw_torch && cur_ff.p1_sync[1];
    assign rf_sync_input_two = !cur_ff.eff_cfg[flash_gpio_pkg::P2_CTRL]
        && cur_ff.p2_sync[1];
    assign hw_torch_sel   = cur_ff.hw_torch;
    assign event_flag_set = cur_ff.flag_set;
    assign reg_rdata      = cur_ff.rdata;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_matching_second_write;
        cfg_wr && out_req && (cur_ff.setup == flash_gpio_pkg::SETUP_PENDING)
        && (reg_wdata == cur_ff.last_wr);
    endsequence

    sequence s_first_output_write;
        cfg_wr && (cur_ff.setup == flash_gpio_pkg::SETUP_IDLE);
    endsequence

    AST_FIRST_WRITE_NO_DRIVE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_first_output_write |=> !first_multifunction_pin_oe
            && !second_multifunction_pin_oe)
        else $error("pin driven after one setup write");

    AST_SECOND_WRITE_ARMS: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_matching_second_write |=>
            (cur_ff.setup == flash_gpio_pkg::SETUP_ARMED)
            && (second_multifunction_pin_oe == $past(reg_wdata[4]
                && reg_wdata[3])))
        else $error("second identical write did not arm output");

    AST_SINGLE_WRITE_DATA: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (cfg_wr && cur_ff.setup == flash_gpio_pkg::SETUP_ARMED
            && !reg_wdata[6]) |=>
            second_multifunction_pin_out == $past(reg_wdata[5]))
        else $error("armed single write not applied");

    AST_INPUT_ONLY_ON_WRITE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !cfg_wr |=> $stable(cur_ff.pin_cfg))
        else $error("readback image changed without a write");

    AST_IRQ_DRIVE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        irq_mode |-> second_multifunction_pin_oe
            && (second_multifunction_pin_out == irq_req))
        else $error("interrupt mode not driving pin");

    AST_CAPTURE_WITH_FLAG: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (|event_flag_set) |-> cur_ff.captured
            == $past({led_b_code, led_a_code}))
        else $error("capture not loaded with flag");

    AST_THERM_GATED: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        event_flag_set[0] |-> $past(thermistor_mode)
            && $past(cur_ff.mon_sync[0]))
        else $error("thermistor flag without mode");

    AST_TORCH_CLEAR: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (flash_done && !torch_sel_wr) |=> !hw_torch_sel)
        else $error("torch select not cleared");

    AST_BIT7_ZERO: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (reg_rd_en && reg_addr == flash_gpio_pkg::PIN_CTRL_ADDR)
            |=> !reg_rdata[7])
        else $error("unused bit reads one");

endmodule : flash_gpio_capture

// >>> testbench/host_bus_model.sv
`timescale 1ns/1ps

// host on the register port; each strobe is held for exactly one edge
module host_bus_model (
    input  wire logic       core_clk,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    // idle at time zero
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // one access; address and data are scrambled once the strobe drops
    // so a design that samples late sees garbage, not a stale match
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= wr;
        reg_rd_en <= !wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : access

    // first output setup: the same value written twice
    task automatic setup_output(input logic [7:0] d);
        access(1'b1, flash_gpio_pkg::PIN_CTRL_ADDR, d);
        access(1'b1, flash_gpio_pkg::PIN_CTRL_ADDR, d);
    endtask : setup_output
endmodule : host_bus_model

// >>> testbench/tb_flash_gpio_and_last_level_capture.sv
`timescale 1ns/1ps

module tb_flash_gpio_and_last_level_capture;
    // ****************************************************************
    // signals
    // ****************************************************************
    localparam int SLOW  = 20;
    localparam int DEGL  = flash_gpio_pkg::DEGLITCH_CYCLES;
    localparam int LIMIT = 20000; // whole run is well under this
    logic       core_clk;
    logic       rst_n;
    logic       reg_wr_en, reg_rd_en, rd_seen;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, exp8, keep8;
    logic       p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe;
    logic       sync_one, sync_two, torch_en, irq_req, hw_torch_sel;
    logic       torch_wr, torch_wd, flash_done;
    logic [2:0] cond_v, en_v, event_flag_set;
    logic [3:0] code_a, code_b, sav_a, sav_b;
    logic [7:0] rd_q[$];
    logic [2:0] ev_q[$];
    int         miscompares, n_compared, cyc, stamp, lim, dly, seed;

    // ****************************************************************
    // instances
    // ****************************************************************
    host_bus_model host_bus_model_i (
        .core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    flash_gpio_capture #(.SLOW_CYCLES(SLOW)) flash_gpio_capture_i (
        .core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .first_multifunction_pin_in(p1_in),
        .first_multifunction_pin_out(p1_out),
        .first_multifunction_pin_oe(p1_oe),
        .second_multifunction_pin_in(p2_in),
        .second_multifunction_pin_out(p2_out),
        .second_multifunction_pin_oe(p2_oe), .rf_sync_input_one(sync_one),
        .rf_sync_input_two(sync_two), .torch_enable(torch_en),
        .irq_req(irq_req), .torch_sel_wr(torch_wr),
        .torch_sel_wdata(torch_wd), .flash_done(flash_done),
        .hw_torch_sel(hw_torch_sel), .thermistor_below_trip(cond_v[0]),
        .vin_below_monitor(cond_v[1]), .vin_below_flash_monitor(cond_v[2]),
        .thermistor_mode(en_v[0]), .vin_monitor_en(en_v[1]),
        .flash_monitor_en(en_v[2]), .led_a_code(code_a),
        .led_b_code(code_b), .event_flag_set(event_flag_set));

    // ****************************************************************
    // compare and report
    // ****************************************************************
    task automatic note(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : note
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        note(got === exp, $sformatf("read %h want %h", got, exp));
    endtask : cmp_rd
    task automatic cmp_flag(input logic [2:0] got, input logic [2:0] exp);
        note(got === exp, $sformatf("flags %b want %b", got, exp));
    endtask : cmp_flag
    task automatic cmp_pin(input logic got, input logic exp);
        note(got === exp, $sformatf("pin level %b want %b", got, exp));
    endtask : cmp_pin
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic end_test(input string name);
        $display("test %s done at %0t", name, $time);
    endtask : end_test

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc
    task automatic wr(input logic [7:0] d);
        host_bus_model_i.access(1'b1, flash_gpio_pkg::PIN_CTRL_ADDR, d);
    endtask : wr
    // expectation is queued before the strobe so the watcher finds it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        host_bus_model_i.access(1'b0, a, 8'h00);
    endtask : rd
    task automatic do_reset;
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask : do_reset

    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // watcher: sampled on the falling edge so outputs have settled;
    // read data stands the cycle after the read edge, flags one cycle
    always @(negedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc >= LIMIT)
        begin
            miscompares++;
            print_verdict();
        end
        else
        begin
            if (rd_seen)
            begin
                exp8 = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx;
                cmp_rd(reg_rdata, exp8);
            end
            rd_seen <= reg_rd_en;
            if (event_flag_set !== 3'b000)
            begin
                dly = cyc - stamp;
                cmp_flag(event_flag_set, (ev_q.size() > 0) ?
                         ev_q.pop_front() : 3'b000);
                note(dly >= lim && dly <= lim + 6,
                     "event delay");
            end
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        {rst_n, p1_in, p2_in, irq_req} = 4'b0000;
        {torch_wr, torch_wd, flash_done} = 3'b000;
        {cond_v, en_v, code_a, code_b} = 14'h0000;
        {miscompares, n_compared, stamp, lim} = '0;
        seed = $urandom(32'h5cbd);
        do_reset();
        rd(flash_gpio_pkg::PIN_CTRL_ADDR, 8'h00);
        rd(flash_gpio_pkg::CAPTURE_ADDR, 8'h00);
        rd(8'h55, 8'h00);
        end_test("reset");

        // output setup takes two identical writes, then single writes
        wr(8'hb8);
        wait_cyc(2);
        cmp_pin(p2_oe, 1'b0);
        wr(8'hb8);
        wait_cyc(2);
        cmp_pin(p2_oe, 1'b1);
        cmp_pin(p2_out, 1'b1);
        wr(8'h98);
        wait_cyc(2);
        cmp_pin(p2_out, 1'b0);
        wr(8'hff);
        wait_cyc(2);
        cmp_pin(p1_oe, 1'b1);
        cmp_pin(p1_out, 1'b1);
        rd(flash_gpio_pkg::PIN_CTRL_ADDR, 8'h7f);
        end_test("output_setup");

        // input bits refresh only on a write
        for (int i = 0; i < 3; i++)
        begin
            {p1_in, p2_in} <= 2'($urandom());
            wait_cyc(4);
            wr(8'h09);
            rd(flash_gpio_pkg::PIN_CTRL_ADDR,
               {2'b00, p2_in, 2'b01, p1_in, 2'b01});
            keep8 = {2'b00, p2_in, 2'b01, p1_in, 2'b01};
            {p1_in, p2_in} <= ~{p1_in, p2_in};
            wait_cyc(4);
            rd(flash_gpio_pkg::PIN_CTRL_ADDR, keep8);
        end
        end_test("input_refresh");

        // sync inputs and torch select
        wr(8'h00);
        {p1_in, p2_in} <= 2'b11;
        wait_cyc(4);
        cmp_pin(sync_one, 1'b1);
        cmp_pin(sync_two, 1'b1);
        cmp_pin(torch_en, 1'b0);
        @(posedge core_clk);
        {torch_wr, torch_wd} <= 2'b11;
        @(posedge core_clk);
        torch_wr <= 1'b0;
        wait_cyc(2);
        cmp_pin(hw_torch_sel, 1'b1);
        cmp_pin(torch_en, 1'b1);
        cmp_pin(sync_one, 1'b0);
        @(posedge core_clk);
        flash_done <= 1'b1;
        @(posedge core_clk);
        flash_done <= 1'b0;
        wait_cyc(2);
        cmp_pin(hw_torch_sel, 1'b0);
        end_test("sync_torch");

        // interrupt mode after a fresh reset
        do_reset();
        wr(8'hf8);
        wait_cyc(2);
        cmp_pin(p2_oe, 1'b0);
        wr(8'hf8);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            irq_req <= 1'($urandom());
            wait_cyc(2);
            cmp_pin(p2_oe, 1'b1);
            cmp_pin(p2_out, irq_req);
        end
        @(posedge core_clk);
        irq_req <= 1'b0;
        wr(8'hb8);
        wait_cyc(2);
        cmp_pin(p2_out, 1'b1);
        end_test("interrupt_mode");

        // protection events: refused while disabled, then captured
        for (int k = 0; k < 3; k++)
        begin
            lim = (k < 2) ? SLOW : DEGL;
            @(posedge core_clk);
            {code_a, code_b} <= 8'($urandom());
            cond_v[k] <= 1'b1;
            wait_cyc(lim + 10);
            {sav_a, sav_b} = {code_a, code_b};
            ev_q.push_back(3'b001 << k);
            @(posedge core_clk);
            en_v[k] <= 1'b1;
            stamp = cyc;
            wait_cyc(lim + 10);
            @(posedge core_clk);
            {cond_v[k], en_v[k]} <= 2'b00;
            {code_a, code_b} <= ~{sav_a, sav_b};
            wait_cyc(2);
            cmp_flag(3'(ev_q.size()), 3'b000);
            rd(flash_gpio_pkg::CAPTURE_ADDR, {sav_b, sav_a});
        end
        end_test("events");
        wait_cyc(4);
        print_verdict();
    end
endmodule : tb_flash_gpio_and_last_level_capture
